// ==== logic/ame_defines.svh ====
/*
 * Shared constants of the address mode decoder: widths, the zero-page high
 * byte and byte counts.
 * Assumes it is included by its bare name wherever the names are used.
 */
`ifndef AME_DEFINES_SVH
`define AME_DEFINES_SVH

// Width of an effective address; the address space is 64 Kbytes.
`define AME_ADDR_W 16
// Widest operand in bits and the width of one memory byte lane.
`define AME_DATA_W 32
`define AME_BYTE_W 8
// High byte forced onto every zero-page address.
`define AME_ZP_HIGH 8'h00
// Byte index of the last byte of a pointer, a word and a long.
`define AME_PTR_LAST 2'h1
`define AME_WORD_LAST 2'h1
`define AME_LONG_LAST 2'h3
// Address step between consecutive bytes of one operand.
`define AME_BYTE_STEP 16'h0001

`endif

// ==== logic/ame_pkg.sv ====
/*
 * Types of the address mode decoder: modes, bases, operand sizes, the
 * request, register, memory and result carriers, and the state record.
 * Assumes ame_defines.svh is on the include path.
 */
`include "ame_defines.svh"

package ame_pkg;

	// Addressing mode class of the instruction in hand.
	typedef enum logic [3:0] {
		REGISTER_ONLY_MODE        = 4'h0,
		LITERAL_OPERAND_MODE      = 4'h1,
		ZERO_PAGE_MODE            = 4'h2,
		ABSOLUTE_MODE             = 4'h3,
		PC_RELATIVE_MODE          = 4'h4,
		SHORT_INDEXED_MODE        = 4'h5,
		AUTO_INDEXED_MODE         = 4'h6,
		ACC_INDEXED_MODE          = 4'h7,
		NINE_BIT_INDEXED_MODE     = 4'h8,
		WIDE_INDEXED_MODE         = 4'h9,
		WIDE_INDIRECT_MODE        = 4'hA,
		ACCUMULATOR_INDIRECT_MODE = 4'hB
	} ame_mode_e;

	typedef enum logic [1:0] {
		BASE_X          = 2'h0,
		BASE_Y          = 2'h1,
		STACK_POINTER   = 2'h2,
		PROGRAM_COUNTER = 2'h3
	} ame_base_e;

	typedef enum logic [1:0] {
		ACC_A = 2'h0,
		ACC_B = 2'h1,
		ACC_D = 2'h2
	} ame_acc_e;

	// Width of the signed offset field carried by the instruction.
	typedef enum logic [1:0] {
		OFF_5  = 2'h0,
		OFF_8  = 2'h1,
		OFF_9  = 2'h2,
		OFF_16 = 2'h3
	} ame_offw_e;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} ame_size_e;

	// Gray path: idle, pointer fetch, data transfer.
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_POINTER = 2'h1,
		ST_DATA    = 2'h3
	} ame_state_e;

	typedef struct packed {
		ame_mode_e                mode;
		ame_base_e                base;
		ame_acc_e                 acc;
		logic [2:0]               step;
		logic                     post;
		logic                     dec;
		ame_offw_e                offw;
		logic [`AME_ADDR_W-1:0]   offset;
		ame_size_e                size;
		logic                     write;
		logic [`AME_DATA_W-1:0]   wdata;
	} ame_req_s;

	typedef struct packed {
		logic [`AME_ADDR_W-1:0] x;
		logic [`AME_ADDR_W-1:0] y;
		logic [`AME_ADDR_W-1:0] sp;
		logic [`AME_ADDR_W-1:0] pc;
		logic [`AME_BYTE_W-1:0] a;
		logic [`AME_BYTE_W-1:0] b;
	} ame_regs_s;

	typedef struct packed {
		logic                   ea;
		logic [`AME_ADDR_W-1:0] addr;
		logic                   idxWe;
		logic [`AME_ADDR_W-1:0] idxVal;
		logic                   ptrFetch;
		logic                   memAccess;
		logic                   err;
	} ame_calc_s;

	typedef struct packed {
		logic                   req;
		logic                   write;
		logic [`AME_ADDR_W-1:0] addr;
		logic [`AME_BYTE_W-1:0] wdata;
	} ame_mem_s;

	typedef struct packed {
		logic                   valid;
		logic                   err;
		logic [`AME_ADDR_W-1:0] ea;
		logic [`AME_DATA_W-1:0] data;
		logic                   idxWe;
		ame_base_e              idxSel;
		logic [`AME_ADDR_W-1:0] idxVal;
	} ame_res_s;

	typedef struct packed {
		ame_state_e             st;
		ame_req_s               req;
		logic [1:0]             cnt;
		logic [`AME_ADDR_W-1:0] ptr;
		logic [`AME_DATA_W-1:0] data;
		logic [`AME_DATA_W-1:0] wsh;
		logic                   idxPend;
		ame_mem_s               mem;
		ame_res_s               res;
	} ame_state_s;

endpackage : ame_pkg

// ==== logic/ame_ea_calc.sv ====
/*
 * Combinational effective address former of the address mode decoder.
 * Assumes the request and register values are stable in the cycle of use.
 */
`timescale 1ns/1ns
`include "ame_defines.svh"

module ame_ea_calc (
	input  ame_pkg::ame_req_s  req,
	input  ame_pkg::ame_regs_s regs,
	output ame_pkg::ame_calc_s calc
);

	logic [`AME_ADDR_W-1:0] baseVal;
	logic [`AME_ADDR_W-1:0] offExt;
	logic [`AME_ADDR_W-1:0] accVal;
	logic [`AME_ADDR_W-1:0] stepVal;
	logic [`AME_ADDR_W-1:0] moved;

	// Base register, accumulator offset and signed constant offset.
	always_comb begin
		case (req.base)
			ame_pkg::BASE_X:        baseVal = regs.x;
			ame_pkg::BASE_Y:        baseVal = regs.y;
			ame_pkg::STACK_POINTER: baseVal = regs.sp;
			default:                baseVal = regs.pc;
		endcase
		case (req.acc)
			ame_pkg::ACC_A: accVal = {8'h00, regs.a};
			ame_pkg::ACC_B: accVal = {8'h00, regs.b};
			default:        accVal = {regs.a, regs.b};
		endcase
		// Sign extension keeps negatives in two's complement.
		case (req.offw)
			ame_pkg::OFF_5: offExt = {{11{req.offset[4]}}, req.offset[4:0]};
			ame_pkg::OFF_8: offExt = {{8{req.offset[7]}}, req.offset[7:0]};
			ame_pkg::OFF_9: offExt = {{7{req.offset[8]}}, req.offset[8:0]};
			default:        offExt = req.offset;
		endcase
	end

	// Auto-modify step of one to eight, applied up or down.
	assign stepVal = {13'h0000, req.step} + `AME_BYTE_STEP;
	assign moved   = req.dec ? baseVal - stepVal : baseVal + stepVal;

	// Address per mode; all sums wrap within 16 bits.
	always_comb begin
		calc = '0;
		case (req.mode)
			ame_pkg::REGISTER_ONLY_MODE: calc.ea = 1'b0;
			ame_pkg::LITERAL_OPERAND_MODE: calc.ea = 1'b0;
			ame_pkg::ZERO_PAGE_MODE: begin
				calc.addr = {`AME_ZP_HIGH, req.offset[7:0]};
				calc.memAccess = 1'b1;
			end
			ame_pkg::ABSOLUTE_MODE: begin
				calc.addr = req.offset;
				calc.memAccess = 1'b1;
			end
			ame_pkg::PC_RELATIVE_MODE: begin
				calc.addr = regs.pc + offExt;
			end
			ame_pkg::AUTO_INDEXED_MODE: begin
				calc.err = (req.base == ame_pkg::PROGRAM_COUNTER);
				calc.addr = (req.post || calc.err) ? baseVal : moved;
				calc.idxWe = !calc.err;
				calc.idxVal = moved;
				calc.memAccess = 1'b1;
			end
			ame_pkg::ACC_INDEXED_MODE: begin
				calc.addr = baseVal + accVal;
				calc.memAccess = 1'b1;
			end
			ame_pkg::WIDE_INDIRECT_MODE: begin
				calc.addr = baseVal + req.offset;
				calc.ptrFetch = 1'b1;
			end
			ame_pkg::ACCUMULATOR_INDIRECT_MODE: begin
				calc.addr = baseVal + {regs.a, regs.b};
				calc.ptrFetch = 1'b1;
			end
			default: begin
				// Short, nine-bit and wide constant offsets.
				calc.addr = baseVal + offExt;
				calc.memAccess = 1'b1;
			end
		endcase
		calc.ea = (req.mode != ame_pkg::REGISTER_ONLY_MODE);
	end

endmodule : ame_ea_calc

// ==== logic/ame_decoder.sv ====
/*
 * Address mode decoder: takes one decoded operand request at a time, forms
 * its effective address and moves the operand over a byte-wide memory port.
 * Assumes a single clock, requests from the instruction queue held until
 * taken, and a memory that answers each byte request with one ack cycle.
 */
`timescale 1ns/1ns
`include "ame_defines.svh"

module ame_decoder (
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   reqValid,
	output      logic                   reqReady,
	input  wire ame_pkg::ame_req_s      reqIn,
	input  wire ame_pkg::ame_regs_s     regs,
	output      ame_pkg::ame_mem_s      memOut,
	input  wire logic [`AME_BYTE_W-1:0] memRdata,
	input  wire logic                   memAck,
	output      ame_pkg::ame_res_s      result
);

	ame_pkg::ame_state_s    s_r;
	ame_pkg::ame_state_s    s_nxt;
	ame_pkg::ame_calc_s     calc;
	logic                   accept;
	logic [1:0]             lastIdx;
	logic [`AME_ADDR_W-1:0] ptrWord;
	logic [`AME_DATA_W-1:0] readWord;
	logic [`AME_DATA_W-1:0] wshInit;
	logic [`AME_DATA_W-1:0] literal;

	// Address former looks at the live request, so no cycle is spent on it.
	ame_ea_calc u_calc (
		.req  (reqIn),
		.regs (regs),
		.calc (calc)
	);

	// A new request is taken only when the previous one has finished.
	assign reqReady = (s_r.st == ame_pkg::ST_IDLE);
	assign accept   = reqValid && reqReady;

	// Memory port and result come straight from the state record.
	assign memOut = s_r.mem;
	assign result = s_r.res;

	// Index of the last byte of the operand in flight.
	always_comb begin
		case (s_r.req.size)
			ame_pkg::SIZE_BYTE: lastIdx = 2'h0;
			ame_pkg::SIZE_WORD: lastIdx = `AME_WORD_LAST;
			default:            lastIdx = `AME_LONG_LAST;
		endcase
	end

	// Bytes arrive high first, so each one shifts in from the right.
	assign ptrWord  = {s_r.ptr[7:0], memRdata};
	assign readWord = {s_r.data[23:0], memRdata};

	// Write data is left-justified so the high byte leaves first.
	always_comb begin
		case (reqIn.size)
			ame_pkg::SIZE_BYTE: wshInit = {reqIn.wdata[7:0], 24'h000000};
			ame_pkg::SIZE_WORD: wshInit = {reqIn.wdata[15:0], 16'h0000};
			default:            wshInit = reqIn.wdata;
		endcase
	end

	// Literal operand is taken as 8 bits for a byte size and as 16 bits for word and long.
	always_comb begin
		if (reqIn.size == ame_pkg::SIZE_BYTE) begin
			literal = {24'h000000, reqIn.offset[7:0]};
		end else begin
			literal = {16'h0000, reqIn.offset};
		end
	end

	// Next-state logic for the whole decoder.
	always_comb begin
		s_nxt = s_r;
		s_nxt.res.valid = 1'b0;
		s_nxt.res.idxWe = 1'b0;
		case (s_r.st)
			ame_pkg::ST_IDLE: begin
				if (accept) begin
					s_nxt.req = reqIn;
					s_nxt.cnt = 2'h0;
					s_nxt.ptr = '0;
					s_nxt.data = '0;
					s_nxt.wsh = wshInit;
					s_nxt.idxPend = calc.idxWe;
					s_nxt.res.ea = calc.addr;
					s_nxt.res.err = calc.err;
					s_nxt.res.idxSel = reqIn.base;
					s_nxt.res.idxVal = calc.idxVal;
					s_nxt.mem.addr = calc.addr;
					s_nxt.mem.wdata = wshInit[31:24];
					if (calc.ptrFetch) begin
						// Indirect: the pointer is read before the operand.
						s_nxt.st = ame_pkg::ST_POINTER;
						s_nxt.mem.req = 1'b1;
						s_nxt.mem.write = 1'b0;
					end else if (calc.memAccess) begin
						s_nxt.st = ame_pkg::ST_DATA;
						s_nxt.mem.req = 1'b1;
						s_nxt.mem.write = reqIn.write;
					end else begin
						// No memory operand: finish at once.
						s_nxt.res.valid = 1'b1;
						s_nxt.res.data = literal;
					end
				end
			end
			ame_pkg::ST_POINTER: begin
				if (memAck) begin
					s_nxt.ptr = ptrWord;
					s_nxt.cnt = s_r.cnt + 2'h1;
					s_nxt.mem.addr = s_r.mem.addr + `AME_BYTE_STEP;
					if (s_r.cnt == `AME_PTR_LAST) begin
						// Pointer complete; it becomes the operand address.
						s_nxt.st = ame_pkg::ST_DATA;
						s_nxt.cnt = 2'h0;
						s_nxt.res.ea = ptrWord;
						s_nxt.mem.addr = ptrWord;
						s_nxt.mem.write = s_r.req.write;
					end
				end
			end
			ame_pkg::ST_DATA: begin
				if (memAck) begin
					s_nxt.data = readWord;
					s_nxt.wsh = {s_r.wsh[23:0], 8'h00};
					s_nxt.mem.wdata = s_r.wsh[23:16];
					s_nxt.mem.addr = s_r.mem.addr + `AME_BYTE_STEP;
					s_nxt.cnt = s_r.cnt + 2'h1;
					if (s_r.cnt == lastIdx) begin
						// Last byte: release the port and report.
						s_nxt.st = ame_pkg::ST_IDLE;
						s_nxt.mem.req = 1'b0;
						s_nxt.res.valid = 1'b1;
						s_nxt.res.idxWe = s_r.idxPend;
						s_nxt.res.data = s_r.req.write ? s_r.req.wdata
							: readWord;
					end
				end
			end
			default: begin
				s_nxt = '0;
			end
		endcase
	end

	// State register; reset clears everything to idle.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Busy decoder never offers to take a new request.
	chk_one_at_time: assert property (
		@(posedge clock) disable iff (!nrst)
		(s_r.st != ame_pkg::ST_IDLE) |-> !reqReady)
		else $error("request offered while busy");

	// Register-only request finishes next cycle with no memory request.
	chk_reg_only_nomem: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::REGISTER_ONLY_MODE)
		|=> (result.valid && !memOut.req))
		else $error("register-only mode touched memory");

	// Byte literal is returned zero-extended from the instruction stream.
	chk_literal_size: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::LITERAL_OPERAND_MODE
		&& reqIn.size == ame_pkg::SIZE_BYTE)
		|=> (result.valid
		&& result.data == {24'h000000, $past(reqIn.offset[7:0])}))
		else $error("byte literal returned wrongly");

	// Zero-page access goes out next cycle with a zero high byte.
	chk_zero_page_high: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::ZERO_PAGE_MODE)
		|=> (memOut.req
		&& memOut.addr == {8'h00, $past(reqIn.offset[7:0])}))
		else $error("zero-page address high byte not zero");

	// Absolute address is put on the port unchanged.
	chk_absolute_direct: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::ABSOLUTE_MODE)
		|=> (memOut.addr == $past(reqIn.offset)))
		else $error("absolute address altered");

	// Short branch target is the following byte plus the signed offset.
	chk_rel_target: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::PC_RELATIVE_MODE
		&& reqIn.offw == ame_pkg::OFF_8)
		|=> (result.valid && result.ea == 16'($past(regs.pc)
		+ {{8{$past(reqIn.offset[7])}}, $past(reqIn.offset[7:0])})))
		else $error("relative target wrong");

	// Pre-modify modes address the already-moved base.
	chk_pre_modify: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && reqIn.mode == ame_pkg::AUTO_INDEXED_MODE
		&& !reqIn.post && reqIn.base != ame_pkg::PROGRAM_COUNTER)
		|-> (calc.addr == calc.idxVal && calc.idxWe))
		else $error("pre-modify address differs from new index");

	// The memory access starts in the cycle after the request is taken.
	chk_no_extra_cyc: assert property (
		@(posedge clock) disable iff (!nrst)
		(accept && (calc.memAccess || calc.ptrFetch))
		|=> (memOut.req && memOut.addr == $past(calc.addr)))
		else $error("address formation cost extra cycles");

	// Consecutive bytes of one operand sit at consecutive addresses.
	chk_byte_order: assert property (
		@(posedge clock) disable iff (!nrst)
		(s_r.st == ame_pkg::ST_DATA && memAck && s_r.cnt != lastIdx)
		|=> (memOut.req
		&& memOut.addr == 16'($past(memOut.addr) + 16'h0001)))
		else $error("operand bytes not consecutive");

endmodule : ame_decoder

// ==== tb/ame_mem_model.sv ====
/*
 * Byte-wide memory model standing on the far side of the address mode
 * decoder.
 * Assumes the decoder holds memOut steady until it sees memAck.
 */
`timescale 1ns/1ns

module ame_mem_model (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire ame_pkg::ame_mem_s memOut,
	input  wire logic [3:0]        waitCycles,
	output      logic [7:0]        memRdata,
	output      logic              memAck
);
	// Full 64 Kbyte space, any byte address, odd or even.
	logic [7:0] store [0:65535];
	logic [3:0] waitCnt;

	// Answers each byte after waitCycles; the data line toggles when idle.
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			memAck   <= 1'b0;
			waitCnt  <= 4'h0;
			memRdata <= 8'h00;
		end else begin
			memAck   <= 1'b0;
			memRdata <= ~memRdata;
			if (memOut.req && !memAck) begin
				if (waitCnt >= waitCycles) begin
					memAck  <= 1'b1;
					waitCnt <= 4'h0;
					if (memOut.write)
						store[memOut.addr] <= memOut.wdata;
					else
						memRdata <= store[memOut.addr];
				end else begin
					waitCnt <= waitCnt + 4'h1;
				end
			end
		end
	end
endmodule : ame_mem_model

// ==== tb/tb_address_mode_decoder.sv ====
/*
 * Self-checking testbench of the address mode decoder with a memory model.
 * Assumes the decoder and its package are compiled before this file.
 */
`timescale 1ns/1ns

module tb_address_mode_decoder;
	logic               clock;
	logic               nrst;
	logic               reqValid;
	logic               reqReady;
	logic               memAck;
	logic [7:0]         memRdata;
	logic [3:0]         waitCycles;
	ame_pkg::ame_req_s  reqIn;
	ame_pkg::ame_regs_s regs;
	ame_pkg::ame_mem_s  memOut;
	ame_pkg::ame_res_s  result;
	ame_pkg::ame_res_s  res;
	int                 errors;
	int                 check_count;
	int                 cycles;
	int                 ackSeen;

	ame_decoder dut_u (.clock(clock), .nrst(nrst), .reqValid(reqValid),
		.reqReady(reqReady), .reqIn(reqIn), .regs(regs), .memOut(memOut),
		.memRdata(memRdata), .memAck(memAck), .result(result));

	ame_mem_model memU (.clock(clock), .nrst(nrst), .memOut(memOut),
		.waitCycles(waitCycles), .memRdata(memRdata), .memAck(memAck));

	// Free-running 100 MHz clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Counts byte answers and cuts a hang short.
	always @(posedge clock) begin
		cycles++;
		if (memAck === 1'b1)
			ackSeen++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic ame_pkg::ame_req_s mk(input ame_pkg::ame_mode_e m,
		input ame_pkg::ame_base_e b, input ame_pkg::ame_offw_e w,
		input logic [15:0] off);
		ame_pkg::ame_req_s r;
		r        = '0;
		r.mode   = m;
		r.base   = b;
		r.offw   = w;
		r.offset = off;
		return r;
	endfunction : mk

	// Issues one request, checks busy, answer time when no bytes move, byte count and error.
	task automatic run(input ame_pkg::ame_req_s r, input int nBytes,
		input logic expErr);
		int n;
		@(posedge clock);
		reqIn    <= r;
		reqValid <= 1'b1;
		@(negedge clock);
		chk(reqReady, 32'h1);
		@(posedge clock);
		reqValid <= 1'b0;
		ackSeen  = 0;
		for (n = 1; n < 80; n++) begin
			@(negedge clock);
			if (result.valid === 1'b1)
				break;
			chk(reqReady, 32'h0);
		end
		if (nBytes == 0)
			chk(n, 32'h1);
		chk(ackSeen, nBytes);
		chk(result.err, expErr);
		res = result;
		@(negedge clock);
		chk(result.valid, 32'h0);
	endtask : run

	// Effective address of one request moving nBytes bytes, read or write.
	task automatic ea_of(input ame_pkg::ame_req_s r, input int nBytes,
		input logic [15:0] expEa);
		run(r, nBytes, 1'b0);
		chk(res.ea, expEa);
	endtask : ea_of

	task automatic t_no_mem();
		ame_pkg::ame_req_s r;
		r = mk(ame_pkg::REGISTER_ONLY_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h4000);
		run(r, 0, 1'b0);
		r = mk(ame_pkg::LITERAL_OPERAND_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h12AB);
		run(r, 0, 1'b0);
		chk(res.data, 32'h0000_00AB);
		r.size = ame_pkg::SIZE_WORD;
		run(r, 0, 1'b0);
		chk(res.data, 32'h0000_12AB);
	endtask : t_no_mem

	task automatic t_direct();
		ame_pkg::ame_req_s r;
		r = mk(ame_pkg::ZERO_PAGE_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h7755);
		ea_of(r, 1, 16'h0055);
		chk(res.data, 32'h0000_003C);
		r = mk(ame_pkg::ABSOLUTE_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h4001);
		r.size = ame_pkg::SIZE_WORD;
		ea_of(r, 2, 16'h4001);
		chk(res.data, 32'h0000_A1B2);
	endtask : t_direct

	task automatic t_long();
		ame_pkg::ame_req_s r;
		r = mk(ame_pkg::ABSOLUTE_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'hFFFE);
		r.size  = ame_pkg::SIZE_LONG;
		r.write = 1'b1;
		r.wdata = 32'h1122_3344;
		waitCycles <= 4'h3;
		ea_of(r, 4, 16'hFFFE);
		chk({memU.store[16'hFFFE], memU.store[16'hFFFF],
			memU.store[16'h0000], memU.store[16'h0001]},
			32'h1122_3344);
		r.write = 1'b0;
		waitCycles <= 4'h0;
		ea_of(r, 4, 16'hFFFE);
		chk(res.data, 32'h1122_3344);
	endtask : t_long

	task automatic t_relative();
		ame_pkg::ame_req_s r;
		r = mk(ame_pkg::PC_RELATIVE_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_8, 16'h00FE);
		ea_of(r, 0, 16'h0FFE);
		r.offset = 16'h007F;
		ea_of(r, 0, 16'h107F);
		r.offw   = ame_pkg::OFF_16;
		r.offset = 16'hFFFC;
		ea_of(r, 0, 16'h0FFC);
	endtask : t_relative

	task automatic t_indexed();
		ea_of(mk(ame_pkg::SHORT_INDEXED_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_5, 16'h0010), 1, 16'h1FF0);
		ea_of(mk(ame_pkg::SHORT_INDEXED_MODE, ame_pkg::PROGRAM_COUNTER,
			ame_pkg::OFF_5, 16'h000F), 1, 16'h100F);
		ea_of(mk(ame_pkg::NINE_BIT_INDEXED_MODE, ame_pkg::BASE_Y,
			ame_pkg::OFF_9, 16'h01FF), 1, 16'h2FFF);
		ea_of(mk(ame_pkg::NINE_BIT_INDEXED_MODE, ame_pkg::BASE_Y,
			ame_pkg::OFF_9, 16'h00FF), 1, 16'h30FF);
		ea_of(mk(ame_pkg::WIDE_INDEXED_MODE, ame_pkg::STACK_POINTER,
			ame_pkg::OFF_16, 16'hF000), 1, 16'hF800);
		ea_of(mk(ame_pkg::WIDE_INDEXED_MODE, ame_pkg::BASE_Y,
			ame_pkg::OFF_16, 16'hE000), 1, 16'h1000);
	endtask : t_indexed

	task automatic t_acc();
		ame_pkg::ame_req_s r;
		r = mk(ame_pkg::ACC_INDEXED_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h0000);
		r.acc = ame_pkg::ACC_A;
		ea_of(r, 1, 16'h20F0);
		r.acc  = ame_pkg::ACC_B;
		r.base = ame_pkg::PROGRAM_COUNTER;
		ea_of(r, 1, 16'h1005);
		r.acc  = ame_pkg::ACC_D;
		r.base = ame_pkg::STACK_POINTER;
		ea_of(r, 1, 16'hF805);
	endtask : t_acc

	// Auto-modify: base register, step, direction and expected results.
	task automatic auto1(input ame_pkg::ame_base_e b, input logic [2:0] st,
		input logic post, input logic dec, input logic [15:0] expEa,
		input logic [15:0] expIdx, input logic expErr);
		ame_pkg::ame_req_s r;
		r      = mk(ame_pkg::AUTO_INDEXED_MODE, b, ame_pkg::OFF_16, 16'h0);
		r.step = st;
		r.post = post;
		r.dec  = dec;
		run(r, 1, expErr);
		chk(res.ea, expEa);
		chk(res.idxWe, !expErr);
		if (!expErr) begin
			chk(res.idxSel, b);
			chk(res.idxVal, expIdx);
		end
	endtask : auto1

	task automatic t_auto();
		auto1(ame_pkg::STACK_POINTER, 3'h7, 1'b0, 1'b1,
			16'h07F8, 16'h07F8, 1'b0);
		auto1(ame_pkg::BASE_X, 3'h0, 1'b1, 1'b0,
			16'h2000, 16'h2001, 1'b0);
		auto1(ame_pkg::BASE_Y, 3'h2, 1'b0, 1'b0,
			16'h3003, 16'h3003, 1'b0);
		auto1(ame_pkg::BASE_X, 3'h3, 1'b1, 1'b1,
			16'h2000, 16'h1FFC, 1'b0);
		auto1(ame_pkg::PROGRAM_COUNTER, 3'h1, 1'b0, 1'b1,
			16'h1000, 16'h0000, 1'b1);
	endtask : t_auto

	task automatic t_indirect();
		waitCycles <= 4'h2;
		ea_of(mk(ame_pkg::WIDE_INDIRECT_MODE, ame_pkg::BASE_X,
			ame_pkg::OFF_16, 16'h0100), 3, 16'h5001);
		chk(res.data, 32'h0000_009D);
		ea_of(mk(ame_pkg::ACCUMULATOR_INDIRECT_MODE, ame_pkg::BASE_Y,
			ame_pkg::OFF_16, 16'h0000), 3, 16'h5001);
		chk(res.data, 32'h0000_009D);
		waitCycles <= 4'h0;
	endtask : t_indirect

	// Main sequence: memory preload, reset, then every scenario.
	initial begin
		errors       = 0;
		check_count  = 0;
		cycles       = 0;
		ackSeen      = 0;
		nrst         = 1'b0;
		reqValid     = 1'b0;
		reqIn        = '0;
		waitCycles   = 4'h0;
		regs         = {16'h2000, 16'h3000, 16'h0800, 16'h1000, 8'hF0, 8'h05};
		memU.store[16'h0055] = 8'h3C;
		memU.store[16'h4001] = 8'hA1;
		memU.store[16'h4002] = 8'hB2;
		memU.store[16'h2100] = 8'h50;
		memU.store[16'h2101] = 8'h01;
		memU.store[16'h2005] = 8'h50;
		memU.store[16'h2006] = 8'h01;
		memU.store[16'h5001] = 8'h9D;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk(reqReady, 32'h1);
		chk(memOut.req, 32'h0);
		t_no_mem();
		t_direct();
		t_long();
		t_relative();
		t_indexed();
		t_acc();
		t_auto();
		t_indirect();
		summarize();
	end
endmodule : tb_address_mode_decoder
